// file: include/dcm_bus_if.sv
/*
   Channel bus between the bus controller and one channel device.
   Open-drain lines are resolved here as wired-OR of asserted levels;
   all levels are logical, 1 = asserted.
*/
`default_nettype none

interface dcm_bus_if;
   logic        ack;
   logic        istb;
   logic        ostb;
   logic        prio;
   logic        req;
   logic        mode_o;
   logic        mode_oe;
   logic        ds0_o;
   logic        ds0_oe;
   logic [15:0] dev_dat_o;
   logic        dev_dat_oe;
   logic [15:0] host_dat_o;
   logic        host_dat_oe;
   logic [2:0]  ext_o;
   logic        ext_oe;
   logic [15:0] dat;
   logic        mode_line;
   logic        ds0_line;
   logic [2:0]  ext;

   assign dat       = (dev_dat_oe ? dev_dat_o : 16'h0000)
                    | (host_dat_oe ? host_dat_o : 16'h0000);
   assign mode_line = mode_oe & mode_o;
   assign ds0_line  = ds0_oe & ds0_o;
   assign ext       = ext_oe ? ext_o : 3'h0;

   modport device (
      input  ack, istb, ostb, prio, dat,
      output req, mode_o, mode_oe, ds0_o, ds0_oe,
      output dev_dat_o, dev_dat_oe, ext_o, ext_oe
   );

   modport host (
      input  req, dat, mode_line, ds0_line, ext,
      output ack, istb, ostb, prio, host_dat_o, host_dat_oe
   );
endinterface : dcm_bus_if

`default_nettype wire

// file: include/dcm_pkg.sv
/*
   Shared constants and types for the data channel transfer logic:
   strobe timing, transfer modes, map table layout, addressing schemes
   and the controller's own AXI4-Lite register map.
   Assumes a 10 MHz aclk.
*/
`default_nettype none

package dcm_pkg;

   // Clock and bus timing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned ACK_NS        = 400;
   localparam int unsigned SETTLE_NS     = 200;
   localparam int unsigned STROBE_NS     = 400;
   localparam int unsigned HOLD_NS       = 100;
   localparam int unsigned ACK_CYC    = (ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W      = 4;

   // Data lines and address layout
   localparam int unsigned DATA_W       = 16;
   localparam int unsigned EXT_W        = 3;
   localparam int unsigned LOGICAL_W    = DATA_W + EXT_W;
   localparam int unsigned PAGE_OFS_W   = 10;
   localparam int unsigned SLOT_W       = 9;
   localparam int unsigned UNMAP_W      = 15;
   localparam int unsigned HALF_SEL_BIT = 15;
   localparam int unsigned PHYS_W       = DATA_W + PAGE_OFS_W;

   // Map table: channel register numbers 4000..5777 octal
   localparam int unsigned MAP_SLOTS   = 512;
   localparam int unsigned MAP_IDX_W   = 10;
   localparam logic [11:0] MAP_REG_BASE = 12'h800;
   localparam logic [11:0] MAP_LAST_15  = 12'h83f;
   localparam logic [11:0] MAP_LAST_16  = 12'h87f;
   localparam logic [11:0] MAP_LAST_12  = 12'h8ff;
   localparam logic [11:0] MAP_LAST_19  = 12'hbff;

   // Even (attribute) word fields
   localparam int unsigned ATTR_DENY_BIT = 0;
   localparam int unsigned ATTR_ZERO_BIT = 1;
   localparam logic [15:0] ATTR_KEEP     = 16'h0003;

   // Transfer mode, coded {select bit 0, mode line}, 1 = asserted
   typedef enum logic [1:0] {
      DCM_OUTPUT, DCM_INPUT, DCM_RESERVED, DCM_MAP_LOAD
   } dcm_mode_type;

   // Device address width
   typedef enum logic [1:0] {
      DCM_ADDR15, DCM_ADDR16, DCM_ADDR12, DCM_ADDR19
   } dcm_scheme_type;

   // AXI4-Lite register map
   localparam int unsigned AXI_AW    = 8;
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_STATUS  = 8'h04;
   localparam logic [7:0] REG_OUTWORD = 8'h08;
   localparam logic [7:0] REG_PHYS    = 8'h0c;
   localparam logic [7:0] REG_INWORD  = 8'h10;
   localparam logic [7:0] REG_MAPIDX  = 8'h14;
   localparam logic [7:0] REG_MAPDATA = 8'h18;

   localparam int unsigned CTRL_SERVICE_BIT = 0;
   localparam int unsigned CTRL_MAPEN_BIT   = 1;
   localparam int unsigned CTRL_SCHEME_LSB  = 2;
   localparam logic [3:0]  CTRL_RESET       = 4'h0;

   localparam int unsigned ST_DONE_BIT  = 0;
   localparam int unsigned ST_FAULT_BIT = 1;
   localparam int unsigned ST_RSV_BIT   = 2;
   localparam int unsigned ST_LOAD_BIT  = 3;
   localparam int unsigned ST_BUSY_BIT  = 4;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dcm_pkg

`default_nettype wire

// file: rtl/dcm_device.sv
/*
   Channel device end: requests a transfer, answers the acknowledge
   with mode and address, supplies or takes one data word.
   Assumes the controller end drives the strobes on the same aclk.
*/
`default_nettype none

module dcm_device (
   // Clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // User request
   input  wire logic                  start,
   input  wire dcm_pkg::dcm_mode_type mode_sel,
   input  wire logic [15:0]           address,
   input  wire logic [2:0]            ext_addr,
   input  wire logic [15:0]           out_word,
   // User answer
   output logic                       busy,
   output logic [15:0]                rx_word,
   output logic                       rx_valid,
   output logic                       done,
   // Channel bus
   dcm_bus_if.device                  bus
);
   import dcm_pkg::*;

   logic         ack_q;
   logic         istb_q;
   logic         ostb_q;
   logic         request;
   logic         selected;
   dcm_mode_type lat_mode;
   logic [15:0]  lat_addr;
   logic [2:0]   lat_ext;
   logic [15:0]  lat_word;
   logic [15:0]  dat_q;
   logic         ack_rise;
   logic         istb_fall;
   logic         ostb_fall;

   assign ack_rise  = bus.ack & ~ack_q;
   assign istb_fall = istb_q & ~bus.istb;
   assign ostb_fall = ostb_q & ~bus.ostb;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ack_q  <= 1'b0;
         istb_q <= 1'b0;
         ostb_q <= 1'b0;
      end
      else
      begin
         ack_q  <= bus.ack;
         istb_q <= bus.istb;
         ostb_q <= bus.ostb;
      end
   end

   // Request flag and latched transfer description
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         request  <= 1'b0;
         lat_mode <= DCM_OUTPUT;
         lat_addr <= 16'h0000;
         lat_ext  <= 3'h0;
         lat_word <= 16'h0000;
      end
      else if (start && !request)
      begin
         request  <= 1'b1;
         lat_mode <= mode_sel;
         lat_addr <= address;
         lat_ext  <= ext_addr;
         lat_word <= out_word;
      end
      else if (ack_rise && bus.prio)
         request <= 1'b0;
   end

   // Selected flag, decided at each acknowledge leading edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         selected <= 1'b0;
      else if (ack_rise)
         selected <= request & bus.prio;
   end

   // Word to drive: address word during acknowledge, data afterwards
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         dat_q <= 16'h0000;
      else if (bus.ack)
         dat_q <= lat_addr;
      else
         dat_q <= lat_word;
   end

   assign bus.req = request;

   // Mode lines held for as long as selected
   assign bus.mode_o  = lat_mode[0];
   assign bus.mode_oe = selected & lat_mode[0];
   assign bus.ds0_o   = lat_mode[1];
   assign bus.ds0_oe  = selected & lat_mode[1];

   assign bus.dev_dat_o  = dat_q;
   assign bus.dev_dat_oe = selected & (bus.ack | bus.istb);
   assign bus.ext_o      = lat_ext;
   assign bus.ext_oe     = selected & bus.ack;

   // Output word taken at the strobe's trailing edge
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_word  <= 16'h0000;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_valid <= selected & ostb_fall;
         if (selected && ostb_fall)
            rx_word <= bus.dat;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         done <= 1'b0;
      else
         done <= selected & (istb_fall | ostb_fall);
   end

   assign busy = request;

endmodule : dcm_device

`default_nettype wire

// file: rtl/dcm_host.sv
/*
   Channel bus controller end: runs acknowledge and strobe sequences,
   holds the map table and translates addresses. Software reaches it
   over AXI4-Lite. Assumes one device and one register master on aclk.
*/
// The implementer's own choices: register access over AXI4-Lite and the address map.
// Contract
// - 15-bit addresses reach 32 slots, 4000-4077
// - 16-bit addresses reach 64 slots, 4000-4177
// - 12-bit scheme reaches 128 slots, 4000-4377
// - Device holds mode lines while selected
// - Select bit and mode line encode mode
// - Selected device drives data during input strobe
// - Controller captures data when input strobe ends
// - Controller drives output word, then strobes
// - Device takes output word on trailing edge
// - Map table holds 512 two-register slots
// - Map load writes one register per operation
// - Address bit 15 picks slot register half
// - Map load and mapping need map enable
// - Each controller keeps own map enable
// - Map load asserts both mode signals
// - Slot number width matches slot count
// - Denied page raises map validity fault
// - Zero bit transfers zeros instead of data
// - Attribute reserved bits read zero
// - Odd register holds page base address
// - Selected flag set on acknowledge edge
// - Unmapped uses low 15 address bits
`default_nettype none

module dcm_host (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write
   input  wire logic [dcm_pkg::AXI_AW-1:0] s_axi_awaddr,
   input  wire logic                       s_axi_awvalid,
   output logic                            s_axi_awready,
   input  wire logic [31:0]                s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output logic                            s_axi_wready,
   output logic [1:0]                      s_axi_bresp,
   output logic                            s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // AXI4-Lite read
   input  wire logic [dcm_pkg::AXI_AW-1:0] s_axi_araddr,
   input  wire logic                       s_axi_arvalid,
   output logic                            s_axi_arready,
   output logic [31:0]                     s_axi_rdata,
   output logic [1:0]                      s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Channel bus
   dcm_bus_if.host                         bus
);
   import dcm_pkg::*;

   typedef enum logic [2:0] {
      H_IDLE, H_ACK, H_XLATE, H_SETTLE, H_OSTB, H_HOLD, H_ISTB
   } dcm_hstate_type;

   dcm_hstate_type state;
   logic [CNT_W-1:0] cnt;
   logic [15:0]      map_mem [0:2*MAP_SLOTS-1];
   logic [3:0]       ctrl;
   logic [3:0]       status;
   logic [15:0]      out_word;
   logic [PHYS_W-1:0] phys;
   logic [15:0]      in_word;
   logic [MAP_IDX_W-1:0] map_idx;
   dcm_mode_type     mode;
   logic [15:0]      addr_w;
   logic [2:0]       ext_w;
   logic             aw_got;
   logic             w_got;
   logic [7:0]       aw_a;
   logic [31:0]      w_d;
   logic [3:0]       w_s;
   logic             wr_fire;
   logic [7:0]       wa;
   logic [7:0]       ra;
   logic             map_en;
   dcm_scheme_type   scheme;
   logic [8:0]       slot_mask;
   logic [LOGICAL_W-1:0] logical;
   logic [SLOT_W-1:0] page;
   logic [SLOT_W-1:0] ld_slot;
   logic [15:0]      attr;
   logic [15:0]      base;
   logic             deny;
   logic             zero;
   logic             ld_go;
   logic [MAP_IDX_W-1:0] ld_idx;
   logic [15:0]      ld_val;

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            res[8*i +: 8] = new_v[8*i +: 8];
      return res;
   endfunction : merge

   assign map_en = ctrl[CTRL_MAPEN_BIT];
   assign scheme = dcm_scheme_type'(ctrl[CTRL_SCHEME_LSB +: 2]);

   // Slot mask from the register number span of each scheme
   always_comb
   begin
      case (scheme)
         DCM_ADDR15: slot_mask = 9'((MAP_LAST_15 - MAP_REG_BASE) >> 1);
         DCM_ADDR16: slot_mask = 9'((MAP_LAST_16 - MAP_REG_BASE) >> 1);
         DCM_ADDR12: slot_mask = 9'((MAP_LAST_12 - MAP_REG_BASE) >> 1);
         default:    slot_mask = 9'((MAP_LAST_19 - MAP_REG_BASE) >> 1);
      endcase
   end

   assign logical = {ext_w, addr_w};
   assign page    = logical[LOGICAL_W-1:PAGE_OFS_W] & slot_mask;
   assign ld_slot = addr_w[SLOT_W-1:0] & slot_mask;
   assign attr    = map_mem[{page, 1'b0}] & ATTR_KEEP;
   assign base    = map_mem[{page, 1'b1}];
   assign deny    = map_en & attr[ATTR_DENY_BIT];
   assign zero    = map_en & attr[ATTR_ZERO_BIT];

   // Map load: bit 15 set selects the even (high-order) register
   assign ld_idx = {ld_slot, ~addr_w[HALF_SEL_BIT]};
   assign ld_val = addr_w[HALF_SEL_BIT] ? (bus.dat & ATTR_KEEP) : bus.dat;
   assign ld_go  = (state == H_ISTB) && (cnt == 0) && (mode == DCM_MAP_LOAD)
                 && map_en;

   // Sequencer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state <= H_IDLE;
         cnt   <= '0;
         mode  <= DCM_OUTPUT;
         addr_w <= 16'h0000;
         ext_w <= 3'h0;
      end
      else
      begin
         case (state)
            H_IDLE:
               if (bus.req && ctrl[CTRL_SERVICE_BIT])
               begin
                  state <= H_ACK;
                  cnt   <= CNT_W'(ACK_CYC - 1);
               end
            H_ACK:
               if (cnt != 0)
                  cnt <= cnt - 1'b1;
               else
               begin
                  mode   <= dcm_mode_type'({bus.ds0_line, bus.mode_line});
                  addr_w <= bus.dat;
                  ext_w  <= bus.ext;
                  state  <= H_XLATE;
               end
            H_XLATE:
               if (mode == DCM_RESERVED || ((mode != DCM_MAP_LOAD) && deny))
                  state <= H_IDLE;
               else if (mode == DCM_OUTPUT)
               begin
                  state <= H_SETTLE;
                  cnt   <= CNT_W'(SETTLE_CYC - 1);
               end
               else
               begin
                  state <= H_ISTB;
                  cnt   <= CNT_W'(STROBE_CYC - 1);
               end
            H_SETTLE:
               if (cnt != 0)
                  cnt <= cnt - 1'b1;
               else
               begin
                  state <= H_OSTB;
                  cnt   <= CNT_W'(STROBE_CYC - 1);
               end
            H_OSTB:
               if (cnt != 0)
                  cnt <= cnt - 1'b1;
               else
               begin
                  state <= H_HOLD;
                  cnt   <= CNT_W'(HOLD_CYC - 1);
               end
            H_HOLD, H_ISTB:
               if (cnt != 0)
                  cnt <= cnt - 1'b1;
               else
                  state <= H_IDLE;
            default:
               state <= H_IDLE;
         endcase
      end
   end

   assign bus.ack  = (state == H_ACK);
   assign bus.istb = (state == H_ISTB);
   assign bus.ostb = (state == H_OSTB);
   assign bus.prio = ctrl[CTRL_SERVICE_BIT];
   assign bus.host_dat_oe = (state == H_SETTLE) || (state == H_OSTB)
                          || (state == H_HOLD);

   // Translation result and data capture
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         phys       <= '0;
         in_word    <= 16'h0000;
         bus.host_dat_o <= 16'h0000;
      end
      else
      begin
         if (state == H_XLATE)
         begin
            if (map_en)
               phys <= {base, logical[PAGE_OFS_W-1:0]};
            else
               phys <= PHYS_W'(logical[UNMAP_W-1:0]);
            bus.host_dat_o <= zero ? 16'h0000 : out_word;
         end
         if (state == H_ISTB && cnt == 0 && mode == DCM_INPUT)
            in_word <= zero ? 16'h0000 : bus.dat;
      end
   end

   // AXI4-Lite write channel, address and data in either order
   assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_got & ~s_axi_bvalid;
   assign wr_fire       = aw_got & w_got & ~s_axi_bvalid;
   assign wa            = {aw_a[7:2], 2'b00};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got <= 1'b0;
         w_got  <= 1'b0;
         aw_a   <= 8'h00;
         w_d    <= 32'h0000_0000;
         w_s    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got <= 1'b1;
            aw_a   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got <= 1'b1;
            w_d   <= s_axi_wdata;
            w_s   <= s_axi_wstrb;
         end
         if (wr_fire)
         begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wa <= REG_MAPDATA) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl     <= CTRL_RESET;
         out_word <= 16'h0000;
         map_idx  <= '0;
      end
      else if (wr_fire)
      begin
         if (wa == REG_CTRL)
            ctrl <= 4'(merge({28'h0, ctrl}, w_d, w_s));
         if (wa == REG_OUTWORD)
            out_word <= 16'(merge({16'h0, out_word}, w_d, w_s));
         if (wa == REG_MAPIDX)
            map_idx <= MAP_IDX_W'(merge({22'h0, map_idx}, w_d, w_s));
      end
   end

   // Sticky status, set wins over write-one-to-clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         status <= 4'h0;
      else
      begin
         for (int i = 0; i < 4; i++)
            if (wr_fire && wa == REG_STATUS && w_s[0] && w_d[i])
               status[i] <= 1'b0;
         if (state == H_ISTB && cnt == 0 && mode == DCM_INPUT)
            status[ST_DONE_BIT] <= 1'b1;
         if (state == H_HOLD && cnt == 0)
            status[ST_DONE_BIT] <= 1'b1;
         if (state == H_XLATE && mode != DCM_MAP_LOAD && deny)
            status[ST_FAULT_BIT] <= 1'b1;
         if (state == H_XLATE && mode == DCM_RESERVED)
            status[ST_RSV_BIT] <= 1'b1;
         if (ld_go)
            status[ST_LOAD_BIT] <= 1'b1;
      end
   end

   // Map table; a device load wins over a software write
   always_ff @(posedge aclk)
   begin
      if (ld_go)
         map_mem[ld_idx] <= ld_val;
      else if (wr_fire && wa == REG_MAPDATA)
         map_mem[map_idx] <= map_idx[0] ? w_d[15:0] : (w_d[15:0] & ATTR_KEEP);
   end

   // AXI4-Lite read channel
   assign s_axi_arready = ~s_axi_rvalid;
   assign ra            = {s_axi_araddr[7:2], 2'b00};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         case (ra)
            REG_CTRL:    s_axi_rdata <= {28'h0, ctrl};
            REG_STATUS:  s_axi_rdata <= {27'h0, state != H_IDLE, status};
            REG_OUTWORD: s_axi_rdata <= {16'h0, out_word};
            REG_PHYS:    s_axi_rdata <= {6'h0, phys};
            REG_INWORD:  s_axi_rdata <= {16'h0, in_word};
            REG_MAPIDX:  s_axi_rdata <= {22'h0, map_idx};
            REG_MAPDATA: s_axi_rdata <= {16'h0, map_mem[map_idx] &
                                         (map_idx[0] ? 16'hffff : ATTR_KEEP)};
            default:
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

endmodule : dcm_host

`default_nettype wire

// file: tb/dcm_chk.sv
/* Channel bus checks between the two ends.
   Assumes the signals of one dcm_bus_if, all on aclk. */
`default_nettype none
module dcm_chk (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Channel bus
   input wire logic        ack,
   input wire logic        istb,
   input wire logic        ostb,
   input wire logic        mode_line,
   input wire logic        ds0_line,
   input wire logic [15:0] dat,
   input wire logic        dev_dat_oe,
   input wire logic        host_dat_oe
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_ack_four_cycles: assert property ($rose(ack) |-> ack[*4] ##1 !ack)
      else $error("ack length wrong");
   a_out_mode_code: assert property (ostb |-> !mode_line && !ds0_line)
      else $error("ostb without output mode");
   a_in_mode_code: assert property (istb |-> mode_line)
      else $error("istb without mode line");
   a_mode_held: assert property (istb |-> $stable({mode_line, ds0_line}))
      else $error("mode lines moved");
   a_in_drive: assert property (istb |-> dev_dat_oe)
      else $error("device not driving");
   a_in_release: assert property (!istb && !ack |-> !dev_dat_oe)
      else $error("device drives outside istb");
   a_out_settle: assert property ($rose(ostb) |-> $past(host_dat_oe, 2) && host_dat_oe)
      else $error("ostb before settle");
   a_out_data_stable: assert property (ostb && $past(ostb) |-> $stable(dat))
      else $error("data moved under ostb");
   a_out_hold: assert property ($fell(ostb) |-> host_dat_oe ##1 !host_dat_oe)
      else $error("output hold wrong");
endmodule : dcm_chk
`default_nettype wire

// file: tb/dcm_tb.sv
/* Testbench: device and controller ends joined by dcm_bus_if.
   Assumes dcm_pkg, dcm_bus_if, dcm_device, dcm_host, dcm_chk. */
`default_nettype none
module dcm_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dcm_pkg::*;
   logic         aclk, aresetn, start, busy, rx_valid, done;
   logic [15:0]  address, out_word, rx_word;
   dcm_mode_type mode_sel;
   logic [7:0]   awaddr, araddr;
   logic [31:0]  wdata, rdata, rd;
   logic         awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready;
   logic [1:0]   bresp, rresp, rs;
   int           err_total, samples_checked, s;
   dcm_bus_if bus ();
   dcm_device i_dcm_device (.aclk(aclk), .aresetn(aresetn), .start(start), .mode_sel(mode_sel),
      .address(address), .ext_addr(3'h0), .out_word(out_word), .busy(busy),
      .rx_word(rx_word), .rx_valid(rx_valid), .done(done), .bus(bus));
   dcm_host i_dcm_host (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bus(bus));
   dcm_chk i_dcm_chk (.aclk(aclk), .aresetn(aresetn), .ack(bus.ack), .istb(bus.istb),
      .ostb(bus.ostb), .mode_line(bus.mode_line), .ds0_line(bus.ds0_line), .dat(bus.dat),
      .dev_dat_oe(bus.dev_dat_oe), .host_dat_oe(bus.host_dat_oe));

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
   endtask : chk

   task axw(input logic [7:0] a, input logic [31:0] d);
      logic aok, wok, bok;
      bok = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bok)
      begin
         @(negedge aclk);
         aok = awvalid & awready;
         wok = wvalid & wready;
         bok = bvalid;
         @(posedge aclk);
         if (aok) awvalid <= 1'b0;
         if (wok) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, bresp});
   endtask : axw

   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic aok, rok;
      rok = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rok)
      begin
         @(negedge aclk);
         aok = arvalid & arready;
         rok = rvalid;
         d = rdata;
         r = rresp;
         @(posedge aclk);
         if (aok) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask : axr

   // One device transfer; done must or must not pulse within the window
   task dev(input dcm_mode_type m, input logic [15:0] a, input logic [15:0] w, input logic ed);
      logic seen, rxv;
      seen = 1'b0;
      rxv = 1'b0;
      @(posedge aclk);
      mode_sel <= m;
      address <= a;
      out_word <= w;
      start <= 1'b1;
      @(posedge aclk);
      start <= 1'b0;
      repeat (40)
      begin
         @(negedge aclk);
         seen = seen | done;
         rxv = rxv | rx_valid;
      end
      chk("done", {31'h0, ed}, {31'h0, seen});
      chk("rx_valid", {31'h0, ed && m == DCM_OUTPUT}, {31'h0, rxv});
      chk("busy", 32'h0, {31'h0, busy});
   endtask : dev

   task st(input logic [31:0] m);
      axr(REG_STATUS, rd, rs);
      chk("status", m, rd & m);
      axw(REG_STATUS, 32'h1f);
   endtask : st

   task report_and_stop;
      $display("checks %0d errors %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : report_and_stop

   initial
   begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   initial
   begin
      #1000000;
      err_total++;
      report_and_stop;
   end

   initial
   begin
      {aresetn, start, awvalid, wvalid, bready, arvalid, rready} = '0;
      {address, out_word, awaddr, araddr, wdata} = '0;
      mode_sel = DCM_OUTPUT;
      err_total = 0;
      samples_checked = 0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      axr(REG_CTRL, rd, rs);
      chk("ctrl", 32'h0, rd);
      axr(8'h1c, rd, rs);
      chk("resp", {30'h0, RESP_SLVERR}, {30'h0, rs});
      axw(REG_CTRL, 32'h1);
      axw(REG_OUTWORD, 32'ha5c3);
      dev(DCM_OUTPUT, 16'h8123, 16'h0, 1'b1);
      chk("rx", 32'ha5c3, {16'h0, rx_word});
      axr(REG_PHYS, rd, rs);
      chk("phys", 32'h0123, rd);
      dev(DCM_INPUT, 16'h0456, 16'h3c5a, 1'b1);
      axr(REG_INWORD, rd, rs);
      chk("inword", 32'h3c5a, rd);
      dev(DCM_RESERVED, 16'h0, 16'h0, 1'b0);
      st(32'h4);
      axw(REG_MAPIDX, 32'hb);
      axw(REG_MAPDATA, 32'h7777);
      dev(DCM_MAP_LOAD, 16'h0005, 16'h1234, 1'b1);
      axr(REG_MAPDATA, rd, rs);
      chk("map off", 32'h7777, rd);
      // Slot 255: last slot of narrow schemes, itself at 19 bits
      for (s = 0; s < 4; s++)
      begin
         axw(REG_CTRL, 32'(3 | (s << 2)));
         dev(DCM_MAP_LOAD, 16'h00ff, 16'(s + 1), 1'b1);
         axw(REG_MAPIDX, 32'((64 << s) - 1));
         axr(REG_MAPDATA, rd, rs);
         chk("slot", 32'(s + 1), rd);
      end
      axw(REG_CTRL, 32'h3);
      dev(DCM_MAP_LOAD, 16'h8005, 16'hfffe, 1'b1);
      dev(DCM_MAP_LOAD, 16'h0005, 16'h1234, 1'b1);
      axw(REG_MAPIDX, 32'ha);
      axr(REG_MAPDATA, rd, rs);
      chk("attr", 32'h2, rd);
      dev(DCM_OUTPUT, 16'h1403, 16'h0, 1'b1);
      chk("zero", 32'h0, {16'h0, rx_word});
      axr(REG_PHYS, rd, rs);
      chk("mapped", 32'h0048d003, rd);
      dev(DCM_MAP_LOAD, 16'h8005, 16'h0001, 1'b1);
      dev(DCM_INPUT, 16'h1403, 16'h5555, 1'b0);
      st(32'h2);
      report_and_stop;
   end
endmodule : dcm_tb
`default_nettype wire
